// *** logic/cpr_pkg.sv ***
// Constants, register map and opcodes of the processor register set.
// Assumes a 125 MHz core clock and a 32-bit classic Wishbone register port.
package cpr_pkg;

  // Address widths and memory regions.
  localparam int unsigned PC_W = 20;
  localparam logic [19:0] EXT_SFR_LO   = 20'hF0000;
  localparam logic [19:0] EXT_SFR_HI   = 20'hF07FF;
  localparam logic [19:0] GPR_LO       = 20'hFFEE0;
  localparam logic [19:0] GPR_HI       = 20'hFFEFF;
  localparam logic [3:0]  PLAIN_UPPER  = 4'hF;
  localparam logic [19:0] VEC_LO_ADDR  = 20'h00000;
  localparam logic [19:0] VEC_HI_ADDR  = 20'h00001;

  // Reset values and the stack pointer step.
  localparam logic [7:0]  PSW_RST      = 8'h06;
  localparam logic [15:0] SP_RST       = 16'h0000;
  localparam logic [3:0]  DBANK_RST    = 4'hF;
  localparam logic [3:0]  BBANK_RST    = 4'h0;
  localparam logic [15:0] SP_STEP      = 16'h0002;

  // Field positions in the status word.
  localparam int unsigned PSW_ALLOW    = 7;
  localparam int unsigned PSW_NULL     = 6;
  localparam int unsigned PSW_BANK_HI  = 5;
  localparam int unsigned PSW_NIBBLE   = 4;
  localparam int unsigned PSW_BANK_LO  = 3;
  localparam int unsigned PSW_LEVEL_HI = 2;
  localparam int unsigned PSW_LEVEL_LO = 1;
  localparam int unsigned PSW_CARRY    = 0;

  // Wishbone byte offsets.
  localparam logic [9:0] OFS_PC        = 10'h000;
  localparam logic [9:0] OFS_PSW       = 10'h004;
  localparam logic [9:0] OFS_SP        = 10'h008;
  localparam logic [9:0] OFS_DBANK     = 10'h00C;
  localparam logic [9:0] OFS_BBANK     = 10'h010;
  localparam logic [9:0] OFS_STATUS    = 10'h014;
  localparam logic [9:0] OFS_GPR_BASE  = 10'h080;
  localparam logic [9:0] OFS_PAIR_BASE = 10'h100;

  // Operations issued by the execution unit.
  typedef enum logic [3:0] {
    CPR_OP_NONE   = 4'h0,
    CPR_OP_SEQ    = 4'h1,
    CPR_OP_BR_IMM = 4'h2,
    CPR_OP_BR_REG = 4'h3,
    CPR_OP_PUSH   = 4'h4,
    CPR_OP_POP    = 4'h5,
    CPR_OP_RETURN_FROM_INTERRUPT   = 4'h6,
    CPR_OP_RETURN_FROM_BREAK   = 4'h7,
    CPR_OP_INTACK = 4'h8,
    CPR_OP_MASK   = 4'h9,
    CPR_OP_UNMASK = 4'hA,
    CPR_OP_BANK   = 4'hB,
    CPR_OP_ADD    = 4'hC,
    CPR_OP_SUB    = 4'hD,
    CPR_OP_ROT    = 4'hE,
    CPR_OP_BIT    = 4'hF
  } cpr_op_t;

  // Reset vector fetch sequence.
  typedef enum logic [1:0] {
    CPR_ST_VLO = 2'b00,
    CPR_ST_VHI = 2'b01,
    CPR_ST_RUN = 2'b10
  } cpr_state_t;

endpackage

// *** logic/cpr_dec_if.sv ***
// Carries a data offset to the address decoder and its decoded result back.
// Assumes both ends sit on the same clock; the decoder is purely combinational.
`timescale 1ns/1ns
interface cpr_dec_if;
  logic [15:0] offset;
  logic        use_bank;
  logic [3:0]  bank;
  logic [19:0] addr;
  logic        ext_sfr;
  logic        gpr_hit;
  logic [4:0]  gpr_index;
  modport req (output offset, use_bank, bank, input addr, ext_sfr, gpr_hit, gpr_index);
  modport dec (input offset, use_bank, bank, output addr, ext_sfr, gpr_hit, gpr_index);
endinterface

// *** logic/cpr_addr_map.sv ***
// Data address builder and region decoder of the processor register set.
// Assumes the requester holds offset and bank steady for the cycle it samples.
`timescale 1ns/1ns
module cpr_addr_map
  import cpr_pkg::*;
(
  cpr_dec_if.dec d
);

  // Plain accesses land in the top 64 Kbytes; banked ones reach the whole space.
  always_comb begin
    if (d.use_bank) begin
      d.addr = {d.bank, d.offset};
    end else begin
      d.addr = {PLAIN_UPPER, d.offset};
    end
  end

  // Region flags. The general registers start on a 32-byte boundary, so the low bits index them.
  assign d.ext_sfr   = (d.addr >= EXT_SFR_LO) && (d.addr <= EXT_SFR_HI);
  assign d.gpr_hit   = (d.addr >= GPR_LO) && (d.addr <= GPR_HI);
  assign d.gpr_index = d.addr[4:0];

endmodule // cpr_addr_map

// *** logic/cpr_top.sv ***
// Processor register set: program counter, status word, stack pointer,
// four banks of general registers and the two upper-address registers.
// Assumes an execution unit on the same clock issuing one operation per cycle,
// a byte-wide program memory port for the reset vector and a Wishbone master.
`timescale 1ns/1ns

module cpr_top
  import cpr_pkg::*;
#(
  parameter int unsigned ADR_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave.
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Reset vector fetch port.
  output logic                  mem_rd_o,
  output logic      [19:0]      mem_addr_o,
  input  wire logic [7:0]       mem_rdata_i,
  input  wire logic             mem_ack_i,
  // Operations from the execution unit.
  input  wire logic             op_valid_i,
  input  wire cpr_op_t          op_code_i,
  input  wire logic [2:0]       op_len_i,
  input  wire logic [19:0]      op_addr_i,
  input  wire logic [7:0]       op_byte_i,
  input  wire logic [7:0]       alu_a_i,
  input  wire logic [7:0]       alu_b_i,
  output logic                  core_ready_o,
  output logic      [7:0]       alu_result_o,
  // Stack memory side.
  output logic                  stk_we_o,
  output logic                  stk_rd_o,
  output logic      [15:0]      stk_addr_o,
  output logic      [7:0]       stk_wdata_o,
  // Interrupt acceptance.
  input  wire logic             irq_req_i,
  input  wire logic             irq_masked_i,
  input  wire logic [1:0]       irq_prio_i,
  output logic                  irq_accept_o,
  // Data address path and general register access.
  input  wire logic [15:0]      dat_off_i,
  input  wire logic             dat_ext_i,
  input  wire logic             gpr_we_i,
  input  wire logic [7:0]       gpr_wdata_i,
  input  wire logic [2:0]       gpr_sel_i,
  output logic      [19:0]      dat_addr_o,
  output logic                  dat_ext_sfr_o,
  output logic                  dat_gpr_o,
  output logic      [7:0]       gpr_mem_rdata_o,
  output logic      [7:0]       gpr_rdata_o,
  output logic      [15:0]      gpr_pair_o,
  // Architectural state views.
  output logic      [19:0]      pc_o,
  output logic      [7:0]       psw_o,
  output logic      [15:0]      sp_o,
  output logic      [3:0]       dbank_o,
  output logic      [3:0]       bbank_o
);

  logic [PC_W-1:0] pc_q;
  logic [7:0]      psw_q;
  logic [15:0]     sp_q;
  logic [3:0]      dbank_q;
  logic [3:0]      bbank_q;
  logic [7:0]      gpr_q [32];
  logic [7:0]      vec_lo_q;
  cpr_state_t      state_q;
  logic            ack_q;
  logic [31:0]     rdat_q;
  logic            op_go;
  logic [1:0]      bank_cur;
  logic [8:0]      sum9;
  logic [4:0]      nib5;
  logic            bus_wr;
  cpr_dec_if       dec ();

  // Bank currently serving execution, kept in the status word.
  function automatic logic [1:0] bank_of(input logic [7:0] program_status_word);
    return {program_status_word[PSW_BANK_HI], program_status_word[PSW_BANK_LO]};
  endfunction

  // Index of register r of bank b in the flat array; bank b sits at base + 8*b.
  function automatic logic [4:0] gpr_at(input logic [1:0] b, input logic [2:0] r);
    return {b, r};
  endfunction

  assign bank_cur = bank_of(psw_q);
  // Operations are only honoured once the reset vector is in place.
  assign op_go    = op_valid_i && (state_q == CPR_ST_RUN);

  // Reset vector fetch: low byte from the even address, then high byte from the odd one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q  <= CPR_ST_VLO;
      vec_lo_q <= 8'h00;
    end else begin
      unique case (state_q)
        CPR_ST_VLO: begin
          if (mem_ack_i) begin
            vec_lo_q <= mem_rdata_i;
            state_q  <= CPR_ST_VHI;
          end
        end
        CPR_ST_VHI: begin
          if (mem_ack_i) begin
            state_q <= CPR_ST_RUN;
          end
        end
        CPR_ST_RUN: begin
          state_q <= CPR_ST_RUN;
        end
        default: begin
          state_q <= CPR_ST_VLO;
        end
      endcase
    end
  end

  assign mem_rd_o     = (state_q == CPR_ST_VLO) || (state_q == CPR_ST_VHI);
  assign mem_addr_o   = (state_q == CPR_ST_VHI) ? VEC_HI_ADDR : VEC_LO_ADDR;
  assign core_ready_o = (state_q == CPR_ST_RUN);

  // Program counter. The vector only reaches the low 64 Kbytes, so bits 19-16 clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= '0;
    end else if ((state_q == CPR_ST_VHI) && mem_ack_i) begin
      pc_q <= {4'h0, mem_rdata_i, vec_lo_q};
    end else if (op_go) begin
      unique case (op_code_i)
        CPR_OP_BR_IMM, CPR_OP_RETURN_FROM_INTERRUPT, CPR_OP_RETURN_FROM_BREAK, CPR_OP_INTACK: begin
          pc_q <= op_addr_i;
        end
        CPR_OP_BR_REG: begin
          pc_q <= {bbank_q, op_addr_i[15:0]};
        end
        default: begin
          pc_q <= pc_q + {17'h00000, op_len_i};
        end
      endcase
    end
  end

  // Arithmetic for flag updates; nine and five bits keep the carries out of bits 7 and 3.
  always_comb begin
    if (op_code_i == CPR_OP_SUB) begin
      sum9 = {1'b0, alu_a_i} - {1'b0, alu_b_i};
      nib5 = {1'b0, alu_a_i[3:0]} - {1'b0, alu_b_i[3:0]};
    end else begin
      sum9 = {1'b0, alu_a_i} + {1'b0, alu_b_i};
      nib5 = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
    end
  end

  // Result register for the execution unit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alu_result_o <= 8'h00;
    end else if (op_go && ((op_code_i == CPR_OP_ADD) || (op_code_i == CPR_OP_SUB))) begin
      alu_result_o <= sum9[7:0];
    end
  end

  assign bus_wr = ack_q && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];

  // Status word. A software write in the same cycle as an operation wins, as the later word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw_q <= PSW_RST;
    end else if (bus_wr && (wb_adr_i == OFS_PSW)) begin
      psw_q <= wb_dat_i[7:0];
    end else if (op_go) begin
      unique case (op_code_i)
        CPR_OP_POP, CPR_OP_RETURN_FROM_INTERRUPT, CPR_OP_RETURN_FROM_BREAK: begin
          psw_q <= op_byte_i;
        end
        CPR_OP_INTACK, CPR_OP_MASK: begin
          psw_q[PSW_ALLOW] <= 1'b0;
        end
        CPR_OP_UNMASK: begin
          psw_q[PSW_ALLOW] <= 1'b1;
        end
        CPR_OP_BANK: begin
          psw_q[PSW_BANK_HI] <= op_byte_i[1];
          psw_q[PSW_BANK_LO] <= op_byte_i[0];
        end
        CPR_OP_ADD, CPR_OP_SUB: begin
          psw_q[PSW_NULL]   <= (sum9[7:0] == 8'h00);
          psw_q[PSW_NIBBLE] <= nib5[4];
          psw_q[PSW_CARRY]  <= sum9[8];
        end
        CPR_OP_ROT, CPR_OP_BIT: begin
          psw_q[PSW_CARRY] <= op_byte_i[0];
        end
        default: begin
          psw_q <= psw_q;
        end
      endcase
    end
  end

  // Maskable acceptance: allow flag first, then source mask, then level (0 is highest).
  assign irq_accept_o = irq_req_i && psw_q[PSW_ALLOW] && !irq_masked_i
                        && (irq_prio_i <= psw_q[PSW_LEVEL_HI:PSW_LEVEL_LO]);

  // Stack pointer: bit 0 never stores a one, so the stack stays word aligned.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_q <= SP_RST;
    end else if (bus_wr && (wb_adr_i == OFS_SP)) begin
      sp_q <= {(wb_sel_i[1] ? wb_dat_i[15:8] : sp_q[15:8]), wb_dat_i[7:1], 1'b0};
    end else if (op_go) begin
      unique case (op_code_i)
        CPR_OP_PUSH, CPR_OP_INTACK: begin
          sp_q <= sp_q - SP_STEP;
        end
        CPR_OP_POP, CPR_OP_RETURN_FROM_INTERRUPT, CPR_OP_RETURN_FROM_BREAK: begin
          sp_q <= sp_q + SP_STEP;
        end
        default: begin
          sp_q <= sp_q;
        end
      endcase
    end
  end

  // Stack port: a save goes to the already lowered address, a restore reads before raising.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stk_we_o    <= 1'b0;
      stk_rd_o    <= 1'b0;
      stk_addr_o  <= 16'h0000;
      stk_wdata_o <= 8'h00;
    end else begin
      stk_we_o <= op_go && ((op_code_i == CPR_OP_PUSH) || (op_code_i == CPR_OP_INTACK));
      stk_rd_o <= op_go && ((op_code_i == CPR_OP_POP) || (op_code_i == CPR_OP_RETURN_FROM_INTERRUPT)
                  || (op_code_i == CPR_OP_RETURN_FROM_BREAK));
      if (op_go && ((op_code_i == CPR_OP_PUSH) || (op_code_i == CPR_OP_INTACK))) begin
        stk_addr_o  <= sp_q - SP_STEP;
        stk_wdata_o <= psw_q;
      end else if (op_go) begin
        stk_addr_o <= sp_q;
      end
    end
  end

  // Upper-address registers; only four bits are stored, the rest read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dbank_q <= DBANK_RST;
      bbank_q <= BBANK_RST;
    end else if (bus_wr && (wb_adr_i == OFS_DBANK)) begin
      dbank_q <= wb_dat_i[3:0];
    end else if (bus_wr && (wb_adr_i == OFS_BBANK)) begin
      bbank_q <= wb_dat_i[3:0];
    end
  end

  // Data address decode through the shared address builder.
  assign dec.offset   = dat_off_i;
  assign dec.use_bank = dat_ext_i;
  assign dec.bank     = dbank_q;

  cpr_addr_map u_map (
    .d (dec.dec)
  );

  // Registered data address outputs and the memory-mapped view of the general registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_addr_o      <= '0;
      dat_ext_sfr_o   <= 1'b0;
      dat_gpr_o       <= 1'b0;
      gpr_mem_rdata_o <= 8'h00;
    end else begin
      dat_addr_o      <= dec.addr;
      dat_ext_sfr_o   <= dec.ext_sfr;
      dat_gpr_o       <= dec.gpr_hit;
      gpr_mem_rdata_o <= dec.gpr_hit ? gpr_q[dec.gpr_index] : 8'h00;
    end
  end

  // General registers. They are RAM cells with no reset; the bus port wins a collision.
  always_ff @(posedge clk_i) begin
    if (bus_wr && (wb_adr_i >= OFS_GPR_BASE) && (wb_adr_i < OFS_PAIR_BASE)) begin
      gpr_q[wb_adr_i[6:2]] <= wb_dat_i[7:0];
    end else if (bus_wr && (wb_adr_i >= OFS_PAIR_BASE) && (wb_adr_i[9:8] == 2'b01)
                 && (wb_adr_i[7:6] == 2'b00)) begin
      gpr_q[{wb_adr_i[5:2], 1'b0}] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) begin
        gpr_q[{wb_adr_i[5:2], 1'b1}] <= wb_dat_i[15:8];
      end
    end else if (gpr_we_i) begin
      gpr_q[gpr_at(bank_cur, gpr_sel_i)] <= gpr_wdata_i;
    end
  end

  // Execution-side reads from the selected bank: one byte and the pair holding it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpr_rdata_o <= 8'h00;
      gpr_pair_o  <= 16'h0000;
    end else begin
      gpr_rdata_o <= gpr_q[gpr_at(bank_cur, gpr_sel_i)];
      gpr_pair_o  <= {gpr_q[gpr_at(bank_cur, {gpr_sel_i[2:1], 1'b1})],
                      gpr_q[gpr_at(bank_cur, {gpr_sel_i[2:1], 1'b0})]};
    end
  end

  // Wishbone answer: one wait state, ack for one cycle, unmapped words read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        if ((wb_adr_i >= OFS_GPR_BASE) && (wb_adr_i < OFS_PAIR_BASE)) begin
          rdat_q <= {24'h000000, gpr_q[wb_adr_i[6:2]]};
        end else if ((wb_adr_i[9:8] == 2'b01) && (wb_adr_i[7:6] == 2'b00)) begin
          rdat_q <= {16'h0000, gpr_q[{wb_adr_i[5:2], 1'b1}], gpr_q[{wb_adr_i[5:2], 1'b0}]};
        end else begin
          unique case (wb_adr_i)
            OFS_PC:     rdat_q <= {12'h000, pc_q};
            OFS_PSW:    rdat_q <= {24'h000000, psw_q};
            OFS_SP:     rdat_q <= {16'h0000, sp_q};
            OFS_DBANK:  rdat_q <= {28'h0000000, dbank_q};
            OFS_BBANK:  rdat_q <= {28'h0000000, bbank_q};
            OFS_STATUS: rdat_q <= {29'h00000000, irq_accept_o, bank_cur};
            default:    rdat_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  assign pc_o    = pc_q;
  assign psw_o   = psw_q;
  assign sp_o    = sp_q;
  assign dbank_o = dbank_q;
  assign bbank_o = bbank_q;

endmodule // cpr_top

// *** dv/cpr_top_assertions.sv ***
// Concurrent checks on the processor register set, watching its top ports only.
// Assumes the bench keeps the register bus idle while it issues core operations.
`timescale 1ns/1ns
module cpr_top_assertions
  import cpr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        mem_rd_o,
  input wire logic [19:0] mem_addr_o,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        mem_ack_i,
  input wire logic        op_valid_i,
  input wire cpr_op_t     op_code_i,
  input wire logic [19:0] op_addr_i,
  input wire logic [7:0]  op_byte_i,
  input wire logic        core_ready_o,
  input wire logic        stk_we_o,
  input wire logic        stk_rd_o,
  input wire logic [15:0] stk_addr_o,
  input wire logic        irq_req_i,
  input wire logic        irq_masked_i,
  input wire logic [1:0]  irq_prio_i,
  input wire logic        irq_accept_o,
  input wire logic [15:0] dat_off_i,
  input wire logic        dat_ext_i,
  input wire logic [19:0] dat_addr_o,
  input wire logic        dat_ext_sfr_o,
  input wire logic [19:0] pc_o,
  input wire logic [7:0]  psw_o,
  input wire logic [15:0] sp_o,
  input wire logic [3:0]  dbank_o,
  input wire logic [3:0]  bbank_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // An operation counts only with the bus idle, since a bus write would win over it.
  logic       tk;
  logic [7:0] vlo_q;
  assign tk = op_valid_i && core_ready_o && !wb_cyc_i;

  // The low vector byte is kept until the high byte arrives.
  always_ff @(posedge clk_i) begin
    if (mem_rd_o && mem_ack_i && mem_addr_o == VEC_LO_ADDR) begin
      vlo_q <= mem_rdata_i;
    end
  end

  sequence s_vec_hi;
    mem_rd_o && mem_ack_i && mem_addr_o == VEC_HI_ADDR;
  endsequence
  sequence s_push;
    tk && op_code_i inside {CPR_OP_PUSH, CPR_OP_INTACK};
  endsequence
  sequence s_pop;
    tk && op_code_i inside {CPR_OP_POP, CPR_OP_RETURN_FROM_INTERRUPT, CPR_OP_RETURN_FROM_BREAK};
  endsequence

  a_vector_load: assert property (
    s_vec_hi |=> core_ready_o && pc_o == {4'h0, $past(mem_rdata_i), vlo_q})
    else $error("Reset vector not loaded into the program counter.");
  a_push_predec: assert property (
    s_push |=> stk_we_o && sp_o == $past(sp_o) - 16'h0002 && stk_addr_o == sp_o)
    else $error("Stack write not preceded by a decrement.");
  a_pop_postinc: assert property (
    s_pop |=> stk_rd_o && stk_addr_o == $past(sp_o) && sp_o == $past(sp_o) + 16'h0002 && psw_o == $past(op_byte_i))
    else $error("Stack read or status restore wrong.");
  a_allow_clear: assert property (
    tk && op_code_i inside {CPR_OP_MASK, CPR_OP_INTACK} |=> !psw_o[PSW_ALLOW])
    else $error("Allow flag not cleared.");
  a_allow_set: assert property (
    tk && op_code_i == CPR_OP_UNMASK |=> psw_o[PSW_ALLOW])
    else $error("Allow flag not set.");
  a_allow_gate: assert property (
    !psw_o[PSW_ALLOW] |-> !irq_accept_o)
    else $error("Request accepted with allow flag clear.");
  a_level_gate: assert property (
    irq_accept_o |-> irq_req_i && !irq_masked_i && irq_prio_i <= psw_o[2:1])
    else $error("Request accepted below the service level.");
  a_reset_values: assert property (
    $fell(rst_i) |-> psw_o == PSW_RST && dbank_o == DBANK_RST && bbank_o == BBANK_RST && !sp_o[0])
    else $error("Register reset value wrong.");
  a_data_addr: assert property (
    1'b1 |=> dat_addr_o == ($past(dat_ext_i) ? {$past(dbank_o), $past(dat_off_i)} : {PLAIN_UPPER, $past(dat_off_i)}))
    else $error("Data address built wrongly.");
  a_ext_decode: assert property (
    dat_ext_sfr_o == (dat_addr_o >= EXT_SFR_LO && dat_addr_o <= EXT_SFR_HI))
    else $error("Extended peripheral region decoded wrongly.");
  a_branch_reg: assert property (
    tk && op_code_i == CPR_OP_BR_REG |=> pc_o == ({$past(bbank_o), 16'h0000} | ($past(op_addr_i) & 20'h0FFFF)))
    else $error("Register branch target wrong.");
  a_wb_one_ack: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus acknowledge not a single pulse after one wait.");
endmodule // cpr_top_assertions

bind cpr_top cpr_top_assertions i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mem_rd_o, .mem_addr_o,
  .mem_rdata_i, .mem_ack_i, .op_valid_i, .op_code_i, .op_addr_i, .op_byte_i, .core_ready_o, .stk_we_o, .stk_rd_o,
  .stk_addr_o, .irq_req_i, .irq_masked_i, .irq_prio_i, .irq_accept_o, .dat_off_i, .dat_ext_i, .dat_addr_o,
  .dat_ext_sfr_o, .pc_o, .psw_o, .sp_o, .dbank_o, .bbank_o);

// *** dv/cpu_processor_registers_tb_top.sv ***
// Self-checking bench for the processor register set with an integer model of its state.
// Assumes cpr_top with its bound checker and one 125 MHz clock.
`timescale 1ns/1ns
module cpu_processor_registers_tb_top
  import cpr_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_rd_o, mem_ack_i, op_valid_i, core_ready_o;
  logic        stk_we_o, stk_rd_o, irq_req_i, irq_masked_i, irq_accept_o, dat_ext_i, gpr_we_i, dat_ext_sfr_o, dat_gpr_o;
  logic [1:0]  irq_prio_i;
  logic [2:0]  op_len_i, gpr_sel_i;
  logic [3:0]  wb_sel_i, dbank_o, bbank_o;
  logic [7:0]  mem_rdata_i, op_byte_i, alu_a_i, alu_b_i, alu_result_o, stk_wdata_o, gpr_wdata_i, psw_o, psw_m;
  logic [7:0]  gpr_mem_rdata_o, gpr_rdata_o, gv [32];
  logic [8:0]  x;
  logic [4:0]  h;
  logic [9:0]  wb_adr_i;
  logic [15:0] stk_addr_o, dat_off_i, gpr_pair_o, sp_o, sp_m, off;
  logic [19:0] mem_addr_o, op_addr_i, dat_addr_o, pc_o, pc_m, a20;
  logic [31:0] wb_dat_i, wb_dat_o, rd, d, seed, mv [5];
  logic [9:0]  ro [5] = '{OFS_PSW, OFS_SP, OFS_DBANK, OFS_BBANK, 10'h3FC};
  logic [31:0] rv [5] = '{PSW_RST, SP_RST, DBANK_RST, BBANK_RST, 32'h0};
  logic [31:0] rm [5] = '{32'hFF, 32'hFFFE, 32'hF, 32'hF, 32'h0};
  cpr_op_t     op_code_i, c;
  int          num_errors, checks;

  cpr_top i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .mem_rd_o, .mem_addr_o, .mem_rdata_i, .mem_ack_i, .op_valid_i, .op_code_i, .op_len_i, .op_addr_i, .op_byte_i,
    .alu_a_i, .alu_b_i, .core_ready_o, .alu_result_o, .stk_we_o, .stk_rd_o, .stk_addr_o, .stk_wdata_o, .irq_req_i,
    .irq_masked_i, .irq_prio_i, .irq_accept_o, .dat_off_i, .dat_ext_i, .gpr_we_i, .gpr_wdata_i, .gpr_sel_i,
    .dat_addr_o, .dat_ext_sfr_o, .dat_gpr_o, .gpr_mem_rdata_o, .gpr_rdata_o, .gpr_pair_o, .pc_o, .psw_o, .sp_o,
    .dbank_o, .bbank_o);

  // Free-running core clock, 8 ns period.
  always #4 clk_i = ~clk_i;

  // Every comparison is counted; a mismatch is reported at once.
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Shift register source of stimulus, so a run is repeatable.
  function automatic logic [31:0] rn();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Classic single cycle; the request stands until ack is sampled, then is released.
  task automatic wb(input logic we, input logic [9:0] a, input logic [31:0] dv);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, dv};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  // One core operation; returns one edge after it was taken so pulses are still visible.
  task automatic op(input cpr_op_t k, input logic [19:0] a, input logic [7:0] b);
    @(posedge clk_i);
    {op_valid_i, op_len_i, op_addr_i, op_byte_i} <= {1'b1, a[2:0], a, b};
    op_code_i <= k;
    {alu_b_i, alu_a_i} <= a[15:0];
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // A hang ends here; the whole sequence needs about 700 cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    finish_test();
  end

  // Main sequence: vector fetch, registers, interrupts, operations, banks, decode.
  initial begin
    {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, mem_rdata_i, mem_ack_i, op_valid_i} = '0;
    {op_len_i, op_addr_i, op_byte_i, alu_a_i, alu_b_i, irq_req_i, irq_masked_i, irq_prio_i} = '0;
    op_code_i = CPR_OP_NONE;
    {dat_off_i, dat_ext_i, gpr_we_i, gpr_wdata_i, gpr_sel_i} = '0;
    {rst_i, wb_sel_i, seed} = {1'b1, 4'hF, 32'hF27B};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("vec_addr", {mem_rd_o, mem_addr_o}, {1'b1, VEC_LO_ADDR});
    d = rn();
    {mem_ack_i, mem_rdata_i} <= {1'b1, d[7:0]};
    @(posedge clk_i);
    mem_rdata_i <= d[15:8];
    @(posedge clk_i);
    mem_ack_i <= 1'b0;
    @(posedge clk_i);
    pc_m = {4'h0, d[15:0]};
    chk("pc_vec", {core_ready_o, pc_o}, {1'b1, pc_m});
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, ro[i], 32'h0);
      chk("reg_rst", rd, rv[i]);
      mv[i] = rn() & rm[i];
      wb(1'b1, ro[i], mv[i] | 32'hFFFF0001 & ~rm[i]);
      wb(1'b0, ro[i], 32'h0);
      chk("reg_rw", rd, mv[i]);
    end
    for (int i = 0; i < 24; i++) begin
      d = rn();
      wb(1'b1, OFS_PSW, d);
      {irq_req_i, irq_masked_i, irq_prio_i} <= {|d[12:11], &d[14:13], d[9:8]};
      @(posedge clk_i);
      chk("irq_acc", irq_accept_o, d[7] & |d[12:11] & ~&d[14:13] & (d[9:8] <= d[2:1]));
    end
    {psw_m, sp_m} = {d[7:0], mv[1][15:0]};
    for (int i = 0; i < 45; i++) begin
      c = cpr_op_t'(i % 15 + 1);
      d = rn();
      op(c, d[19:0], d[27:20]);
      pc_m = c inside {CPR_OP_BR_IMM, CPR_OP_RETURN_FROM_INTERRUPT, CPR_OP_RETURN_FROM_BREAK, CPR_OP_INTACK} ? d[19:0] : pc_m + d[2:0];
      case (c)
        CPR_OP_PUSH, CPR_OP_INTACK: begin
          chk("push", {stk_we_o, stk_addr_o, stk_wdata_o}, {1'b1, sp_m - 16'h2, psw_m});
          sp_m -= 16'h2;
          if (c == CPR_OP_INTACK) psw_m[7] = 1'b0;
        end
        CPR_OP_POP, CPR_OP_RETURN_FROM_INTERRUPT, CPR_OP_RETURN_FROM_BREAK: begin
          chk("pop", {stk_rd_o, stk_addr_o}, {1'b1, sp_m});
          {sp_m, psw_m} = {sp_m + 16'h2, d[27:20]};
        end
        CPR_OP_ADD, CPR_OP_SUB: begin
          x = (c == CPR_OP_ADD) ? d[7:0] + d[15:8] : d[7:0] - d[15:8];
          h = (c == CPR_OP_ADD) ? d[3:0] + d[11:8] : d[3:0] - d[11:8];
          {psw_m[6], psw_m[4], psw_m[0]} = {x[7:0] == 8'h0, h[4], x[8]};
          chk("alu", alu_result_o, x[7:0]);
        end
        CPR_OP_MASK: psw_m[7] = 1'b0;
        CPR_OP_UNMASK: psw_m[7] = 1'b1;
        CPR_OP_BANK: {psw_m[5], psw_m[3]} = d[21:20];
        CPR_OP_ROT, CPR_OP_BIT: psw_m[0] = d[20];
        CPR_OP_BR_REG: pc_m = {mv[3][3:0], d[15:0]};
      endcase
      chk("state", {psw_o, sp_o}, {psw_m, sp_m});
      chk("pc", pc_o, pc_m);
    end
    wb(1'b0, OFS_PC, 32'h0);
    chk("pc_bus", rd, pc_m);
    for (int b = 0; b < 4; b++) begin
      op(CPR_OP_BANK, 20'h0, b[7:0]);
      for (int r = 0; r < 8; r++) begin
        rd = rn();
        gv[8 * b + r] = rd[7:0];
        @(posedge clk_i);
        {gpr_we_i, gpr_sel_i, gpr_wdata_i} <= {1'b1, r[2:0], rd[7:0]};
      end
      @(posedge clk_i);
      gpr_we_i <= 1'b0;
    end
    for (int i = 0; i < 32; i++) begin
      wb(1'b0, OFS_GPR_BASE + 10'(4 * i), 32'h0);
      chk("gpr_bus", rd, gv[i]);
      wb(1'b0, OFS_PAIR_BASE + 10'(2 * i), 32'h0);
      chk("pair_bus", rd, {gv[i | 1], gv[i & 30]});
    end
    for (int r = 0; r < 8; r++) begin
      gpr_sel_i <= r[2:0];
      @(posedge clk_i);
      @(posedge clk_i);
      chk("gpr_pair", {gpr_rdata_o, gpr_pair_o}, {gv[24 + r], gv[25 + (r & 6)], gv[24 + (r & 6)]});
    end
    for (int i = 0; i < 30; i++) begin
      d = rn();
      wb(1'b1, OFS_DBANK, {28'h0, d[19:16]});
      off = d[15:0];
      if (i % 3 == 1) off[15:11] = 5'h0;
      if (i % 3 == 2) off[15:5] = 11'h7F7;
      a20 = d[20] ? {d[19:16], off} : {PLAIN_UPPER, off};
      {dat_off_i, dat_ext_i} <= {off, d[20]};
      @(posedge clk_i);
      @(posedge clk_i);
      chk("decode", {dat_ext_sfr_o, dat_gpr_o, dat_addr_o}, {a20 inside {[EXT_SFR_LO:EXT_SFR_HI]},
        a20 inside {[GPR_LO:GPR_HI]}, a20});
      if (a20 inside {[GPR_LO:GPR_HI]}) chk("gpr_mem", gpr_mem_rdata_o, gv[a20[4:0]]);
    end
    finish_test();
  end
endmodule // cpu_processor_registers_tb_top
